// file: gpled_top.sv
// Three shared pins: software GPIO or active-low link indicators
`default_nettype none
// How it works
// - Each pin is set independently as input, push-pull output or open-drain output by its type field.
// - A pin in indicator mode is open-drain: driven low for the on state, released for high.
// - The speed indicator is low only while a valid link runs at 100 Mb/s.
// - The link indicator is low steadily while the link is valid and no blink runs.
// - Activity makes the link indicator go high for 80 ms then low for at least 80 ms, repeating only on new activity.
// - The duplex indicator is low only while the link is full duplex.
module gpled_top #(
  parameter int unsigned BLINK_CYC = gpled_pkg::BLINK_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [5:0] pin_type_in,
  input wire logic [2:0] led_sel_in,
  input wire logic [2:0] gpio_data_in,
  input wire logic link_valid_in,
  input wire logic speed_100_in,
  input wire logic full_duplex_in,
  input wire logic activity_in,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe_out,
  output logic [2:0] gpio_level_out
);
  typedef enum logic [1:0] {BLK_IDLE, BLK_OFF, BLK_ON} gpled_blink_e;
  localparam int unsigned CW = $clog2(BLINK_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(BLINK_CYC - 1);

  // Last cycle of a timed phase, shared by both phases and the checks
  function automatic logic phase_done(input logic [CW-1:0] cnt);
    return cnt == LAST;
  endfunction

  // Next phase count, cut back to the counter width on purpose
  function automatic logic [CW-1:0] phase_step(input logic [CW-1:0] cnt);
    return CW'(cnt + 1'b1);
  endfunction

  gpled_blink_e state_q;
  logic [CW-1:0] cnt_q;
  logic act_q;
  logic [2:0] sync1_q, sync2_q;
  logic [2:0] led_n;

  // Two-stage synchroniser on pin levels
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_q <= gpled_pkg::SYNC_RST;
      sync2_q <= gpled_pkg::SYNC_RST;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // Readable pin level
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      gpio_level_out <= gpled_pkg::SYNC_RST;
    end else begin
      gpio_level_out <= sync2_q;
    end
  end

  // Activity during a blink is held until the sequencer is back in idle;
  // activity seen in idle starts its blink directly, so it is not held twice
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      act_q <= 1'b0;
    end else if (activity_in && link_valid_in && state_q != BLK_IDLE) begin
      act_q <= 1'b1;
    end else if (state_q == BLK_IDLE || !link_valid_in) begin
      act_q <= 1'b0;
    end
  end

  // Blink sequencer: high phase then minimum low phase
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= BLK_IDLE;
      cnt_q <= '0;
    end else if (!link_valid_in) begin
      state_q <= BLK_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        BLK_IDLE: begin
          cnt_q <= '0;
          if (act_q || activity_in) begin
            state_q <= BLK_OFF;
          end
        end
        BLK_OFF: begin
          if (phase_done(cnt_q)) begin
            cnt_q <= '0;
            state_q <= BLK_ON;
          end else begin
            cnt_q <= phase_step(cnt_q);
          end
        end
        default: begin
          if (phase_done(cnt_q)) begin
            cnt_q <= '0;
            state_q <= BLK_IDLE;
          end else begin
            cnt_q <= phase_step(cnt_q);
          end
        end
      endcase
    end
  end

  // Sequencer steps: a phase still counting, and the last cycle of each phase
  sequence s_phase_mid;
    state_q != BLK_IDLE && link_valid_in && !phase_done(cnt_q);
  endsequence
  sequence s_off_end;
    state_q == BLK_OFF && link_valid_in && phase_done(cnt_q);
  endsequence
  sequence s_on_end;
    state_q == BLK_ON && link_valid_in && phase_done(cnt_q);
  endsequence

  a_phase_count: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_phase_mid |=> (state_q == $past(state_q) && cnt_q == phase_step($past(cnt_q))))
    else $error("blink phase count not advancing");
  a_off_to_on: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_off_end |=> state_q == BLK_ON)
    else $error("high phase did not end");
  a_on_to_idle: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_on_end |=> state_q == BLK_IDLE)
    else $error("low phase did not end");
  a_pending_blink: assert property (@(posedge core_clk_in) disable iff (rst_in)
    s_on_end ##1 (link_valid_in && act_q) |=> state_q == BLK_OFF)
    else $error("held activity did not start a blink");
  a_act_latch: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state_q != BLK_IDLE && link_valid_in && activity_in) |=> act_q)
    else $error("activity during blink not held");
  a_link_abort: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !link_valid_in |=> (state_q == BLK_IDLE && cnt_q == '0))
    else $error("blink not aborted on link loss");

  // Indicator levels, active low
  always_comb begin
    led_n = 3'h7;
    led_n[gpled_pkg::PIN_SPEED] = !(link_valid_in && speed_100_in);
    led_n[gpled_pkg::PIN_LINK] = !(link_valid_in && state_q != BLK_OFF);
    led_n[gpled_pkg::PIN_DUPLEX] = !(link_valid_in && full_duplex_in);
  end

  // Pin drivers per function and type
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_out <= 3'h0;
      pin_oe_out <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (led_sel_in[i]) begin
          pin_out[i] <= 1'b0;
          pin_oe_out[i] <= !led_n[i];
        end else begin
          case (pin_type_in[2*i +: 2])
            gpled_pkg::DIR_PUSH_PULL: begin
              pin_out[i] <= gpio_data_in[i];
              pin_oe_out[i] <= 1'b1;
            end
            gpled_pkg::DIR_OPEN_DRAIN: begin
              pin_out[i] <= 1'b0;
              pin_oe_out[i] <= !gpio_data_in[i];
            end
            default: begin
              pin_out[i] <= 1'b0;
              pin_oe_out[i] <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  a_led_open_drain: assert property (@(posedge core_clk_in) disable iff (rst_in)
    led_sel_in[0] |=> !pin_out[0])
    else $error("indicator pin driven high");
  a_speed_on: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (led_sel_in[0] && link_valid_in && speed_100_in) |=> pin_oe_out[0])
    else $error("speed indicator not low");
  a_duplex_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (led_sel_in[2] && !full_duplex_in) |=> !pin_oe_out[2])
    else $error("duplex indicator low without full duplex");
  a_link_steady: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (led_sel_in[1] && link_valid_in && state_q == BLK_IDLE) |=> pin_oe_out[1])
    else $error("link indicator not low");
  a_blink_start: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state_q == BLK_IDLE && link_valid_in && activity_in) |=> state_q == BLK_OFF)
    else $error("blink not started");
  a_blink_len: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (state_q == BLK_OFF && $past(state_q) != BLK_OFF && link_valid_in) |-> cnt_q == '0)
    else $error("blink phase count not cleared");
  a_pushpull_drv: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (!led_sel_in[1] && pin_type_in[3:2] == gpled_pkg::DIR_PUSH_PULL) |=> pin_oe_out[1])
    else $error("push-pull pin not driven");
  a_input_float: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (!led_sel_in[2] && pin_type_in[5:4] == gpled_pkg::DIR_INPUT) |=> !pin_oe_out[2])
    else $error("input pin driven");
  a_level_read: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ##3 gpio_level_out == $past(pin_in, 3))
    else $error("pin level not reflected");

  // Indicator release, duplex indicator drive and general-purpose drive checks
  a_speed_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (led_sel_in[0] && !(link_valid_in && speed_100_in)) |=> !pin_oe_out[0])
    else $error("speed indicator low without 100 Mb/s link");
  a_duplex_on: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (led_sel_in[2] && link_valid_in && full_duplex_in) |=> pin_oe_out[2])
    else $error("duplex indicator not low");
  a_link_blink_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (led_sel_in[1] && state_q == BLK_OFF) |=> !pin_oe_out[1])
    else $error("link indicator low during blink high phase");
  a_link_lost_off: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (led_sel_in[1] && !link_valid_in) |=> !pin_oe_out[1])
    else $error("link indicator low without link");
  a_opendrain_drv: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (!led_sel_in[0] && pin_type_in[1:0] == gpled_pkg::DIR_OPEN_DRAIN) |=>
      (!pin_out[0] && pin_oe_out[0] == !$past(gpio_data_in[0])))
    else $error("open-drain pin drive wrong");
  a_pushpull_data: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (!led_sel_in[2] && pin_type_in[5:4] == gpled_pkg::DIR_PUSH_PULL) |=> pin_out[2] == $past(gpio_data_in[2]))
    else $error("push-pull pin data wrong");
endmodule
`default_nettype wire

// file: gpled_pkg.sv
// Constants shared by the multiplexed pin and link indicator block
`default_nettype none
package gpled_pkg;
  localparam int unsigned NUM_PINS = 3;
  localparam int unsigned CLK_MHZ = 250;
  // Blink phase length in milliseconds
  localparam int unsigned BLINK_MS = 80;
  // Cycles per phase, 80 ms at 250 MHz
  localparam int unsigned BLINK_CYCLES = BLINK_MS * 1000 * CLK_MHZ;
  // Pin direction/type codes
  localparam logic [1:0] DIR_INPUT = 2'h0;
  localparam logic [1:0] DIR_PUSH_PULL = 2'h1;
  localparam logic [1:0] DIR_OPEN_DRAIN = 2'h2;
  // Indicator positions on the pins
  localparam int unsigned PIN_SPEED = 0;
  localparam int unsigned PIN_LINK = 1;
  localparam int unsigned PIN_DUPLEX = 2;
  // Reset values
  localparam logic [2:0] SYNC_RST = 3'h7;
endpackage
`default_nettype wire

// file: gpled_pad_model.sv
// Pad model: LED line with pull-up, or a board signal
`default_nettype none
module gpled_pad_model (
  input wire logic [2:0] pin_out_in,
  input wire logic [2:0] pin_oe_in,
  input wire logic [2:0] board_val_in,
  input wire logic board_en_in,
  output logic [2:0] pad_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driven bits win, else the board, else the pull-up
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pad_out[i] = pin_oe_in[i] ? pin_out_in[i] : (board_en_in ? board_val_in[i] : 1'b1);
    end
  end
endmodule
`default_nettype wire

// file: tb_gpio_led_status_indicator.sv
// Bench for the shared GPIO and link indicator pins
`default_nettype none
module tb_gpio_led_status_indicator;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, lv = 0, sp = 0, fd = 0, act = 0, ben = 0;
  logic [5:0] ty = 0;
  logic [2:0] sel = 0, d = 0, bv = 0, po, oe, lvl, pad;
  int err_count = 0, checks_done = 0, cyc = 0, n;
  integer seed = 32'h053f;
  // Short blink phase for simulation; the reference lengths use the same value
  localparam int BLINK = 10;
  // Reference model: expected link indicator phase lengths, in samples
  int ph_q[$];
  gpled_top #(.BLINK_CYC(BLINK)) i_gpled_top (.core_clk_in(clk), .rst_in(rst), .pin_type_in(ty),
    .led_sel_in(sel), .gpio_data_in(d), .link_valid_in(lv), .speed_100_in(sp), .full_duplex_in(fd),
    .activity_in(act), .pin_in(pad), .pin_out(po), .pin_oe_out(oe), .gpio_level_out(lvl));
  gpled_pad_model i_gpled_pad_model (.pin_out_in(po), .pin_oe_in(oe), .board_val_in(bv),
    .board_en_in(ben), .pad_out(pad));
  // Clock
  initial forever #2 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Counts samples while the link pin enable holds one value
  task automatic run(logic v, output int k);
    k = 0;
    while (oe[1] === v && k < 40) begin
      k++;
      @(posedge clk);
      #1;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    logic [2:0] eo, ep, on;
    logic [1:0] t;
    repeat (2) @(posedge clk);
    #1 chk("reset oe", 8'h0, 8'(oe));
    chk("reset level", 8'h7, 8'(lvl));
    @(posedge clk);
    rst <= 1'b0;
    $display("test reset done");
    for (int j = 0; j < 200; j++) begin
      @(posedge clk);
      {ty, sel, d, lv, sp, fd} <= 15'($random(seed));
      @(posedge clk);
      #1;
      for (int i = 0; i < 3; i++) begin
        t = ty[2*i+:2];
        on[i] = lv & (i == 0 ? sp : (i == 1 ? 1'b1 : fd));
        eo[i] = sel[i] ? on[i] : (t == gpled_pkg::DIR_PUSH_PULL ? 1'b1 : (t == gpled_pkg::DIR_OPEN_DRAIN ? ~d[i] : 1'b0));
        ep[i] = sel[i] ? ~on[i] : ((t == gpled_pkg::DIR_PUSH_PULL || t == gpled_pkg::DIR_OPEN_DRAIN) ? d[i] : 1'b1);
      end
      chk("pin_oe_out", 8'(eo), 8'(oe));
      chk("pad", 8'(ep), 8'(pad));
    end
    $display("test modes done");
    @(posedge clk);
    ty <= 6'h0;
    sel <= 3'h0;
    ben <= 1'b1;
    for (int j = 0; j < 8; j++) begin
      @(posedge clk);
      bv <= 3'(j);
      repeat (4) @(posedge clk);
      #1 chk("gpio_level_out", 8'(j), 8'(lvl));
    end
    $display("test input done");
    // Off phase, steady cap, off, low phase plus the idle cycle that restarts, off, steady cap
    ph_q = {BLINK, 40, BLINK, BLINK + 1, BLINK, 40};
    // One activity pulse gives exactly one blink, then the indicator stays on
    @(posedge clk);
    {ben, sel, lv, act} <= 6'b001011;
    @(posedge clk);
    act <= 1'b0;
    #1 run(1'b1, n);
    run(1'b0, n);
    chk("off phase", 8'(ph_q.pop_front()), 8'(n));
    run(1'b1, n);
    chk("steady on", 8'(ph_q.pop_front()), 8'(n));
    $display("test single blink done");
    // A second pulse in the low phase is held and starts one more blink afterwards
    @(posedge clk);
    act <= 1'b1;
    @(posedge clk);
    act <= 1'b0;
    #1 run(1'b1, n);
    run(1'b0, n);
    chk("off phase 2", 8'(ph_q.pop_front()), 8'(n));
    @(posedge clk);
    act <= 1'b1;
    @(posedge clk);
    act <= 1'b0;
    #1 run(1'b1, n);
    // Two low-phase samples were spent placing the pulse
    chk("on phase", 8'(ph_q.pop_front()), 8'(n + 2));
    run(1'b0, n);
    chk("off again", 8'(ph_q.pop_front()), 8'(n));
    run(1'b1, n);
    chk("steady on 2", 8'(ph_q.pop_front()), 8'(n));
    $display("test held blink done");
    end_of_test();
  end
endmodule
`default_nettype wire
